// ===== rtl/osg_pkg.sv
// osg_pkg: constants and command codes for the operation status group
// assumes one clock domain; values move as plain 16-bit binary words
package osg_pkg;

  localparam int unsigned OSG_W = 16;

  // condition bit positions
  localparam int unsigned OSG_BIT_IQ_CAL    = 0;
  localparam int unsigned OSG_BIT_SETTLING  = 1;
  localparam int unsigned OSG_BIT_SWEEPING  = 3;
  localparam int unsigned OSG_BIT_MEASURING = 4;
  localparam int unsigned OSG_BIT_WAIT_TRIG = 5;
  localparam int unsigned OSG_BIT_DC_NULL   = 9;
  localparam int unsigned OSG_BIT_BASEBAND  = 10;
  localparam int unsigned OSG_BIT_SWEEP_CALC = 11;
  localparam int unsigned OSG_BIT_TESTER_SYNC = 12;
  localparam int unsigned OSG_BIT_ALWAYS_ZERO = 15;

  // number of synchroniser lanes: nine activity flags above a tied-low lane 0
  localparam int unsigned OSG_NFLAGS = 10;

  // bits that may ever read as one in the condition register
  localparam logic [15:0] OSG_COND_USED  = 16'h1e3b;
  // bits removed by the reduced-feature build
  localparam logic [15:0] OSG_COND_REDUCED = 16'h1411;

  // reset values
  localparam logic [15:0] OSG_RST_ZERO = 16'h0000;
  localparam logic [15:0] OSG_RST_RISE = 16'hffff;
  localparam logic [15:0] OSG_RST_FALL = 16'h0000;

  // command codes on the command port
  typedef enum logic [3:0] {
    OSG_OP_READ_COND,
    OSG_OP_READ_EVENT,
    OSG_OP_READ_RISE,
    OSG_OP_READ_FALL,
    OSG_OP_READ_MASK,
    OSG_OP_WRITE_RISE,
    OSG_OP_WRITE_FALL,
    OSG_OP_WRITE_MASK,
    OSG_OP_CLEAR_STATUS,
    OSG_OP_SUPPRESS_ON,
    OSG_OP_SUPPRESS_OFF
  } osg_op_t;

endpackage

// ===== rtl/osg_flag_sync.sv
// osg_flag_sync: three-stage synchroniser with agreement filter for activity flags
// assumes flags arrive from outside the clk domain
`timescale 1ns/1ps
module osg_flag_sync #(
  parameter int unsigned W = 10
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] flag_in,
  output logic      [W-1:0] flag_out
);

  logic [W-1:0] stage1_r;
  logic [W-1:0] stage2_r;
  logic [W-1:0] stage3_r;
  logic [W-1:0] flag_nxt;

  // a flag changes only once the second and third stages agree
  assign flag_nxt = (stage2_r & stage3_r) | (flag_out & (stage2_r | stage3_r));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1_r <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
      flag_out <= '0;
    end else begin
      stage1_r <= flag_in;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      flag_out <= flag_nxt;
    end
  end

endmodule

// ===== rtl/osg_status_group.sv
// osg_status_group: operation status group with condition, filters, event latch and mask
// assumes host commands arrive one per cycle on the command port in the clk domain
`timescale 1ns/1ps
module osg_status_group #(
  parameter bit HAS_BIT_ERROR_TESTER = 1'b1,
  parameter bit REDUCED_FEATURE      = 1'b0
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         iq_cal_active,
  input  wire logic         settling_active,
  input  wire logic         sweep_active,
  input  wire logic         bit_error_tester_measuring,
  input  wire logic         trigger_wait_active,
  input  wire logic         traffic_channel_sync_mode_en,
  input  wire logic         traffic_channel_sync_armed,
  input  wire logic         dc_coupled_fm_null_active,
  input  wire logic         baseband_busy_summary,
  input  wire logic         sweep_calc_active,
  input  wire logic         bit_error_tester_syncing,
  input  wire logic         cmd_valid,
  input  wire logic [3:0]   cmd_op,
  input  wire logic [15:0]  cmd_wdata,
  output logic              rsp_valid,
  output logic      [15:0]  rsp_data,
  output logic              summary_out,
  output logic              suppress_active
);

  logic [osg_pkg::OSG_NFLAGS-1:0] flag_raw;
  logic [osg_pkg::OSG_NFLAGS-1:0] flag_sync;

  logic [15:0] operation_condition_r;
  logic [15:0] operation_rise_filter_r;
  logic [15:0] operation_fall_filter_r;
  logic [15:0] operation_event_latch_r;
  logic [15:0] operation_event_mask_r;

  logic [15:0] cond_nxt;
  logic [15:0] cond_live;
  logic [15:0] cond_keep;
  logic [15:0] rise_hit;
  logic [15:0] fall_hit;
  logic [15:0] event_set;
  logic [15:0] event_nxt;
  logic [15:0] rise_nxt;
  logic [15:0] fall_nxt;
  logic [15:0] mask_nxt;
  logic [15:0] read_data;
  logic        suppress_nxt;
  logic        summary_nxt;
  logic        rsp_valid_nxt;
  logic [15:0] rsp_data_nxt;

  // bits now high that were low before, limited to the selected filter bits
  function automatic logic [15:0] edge_hits(input logic [15:0] now_v,
                                            input logic [15:0] was_v,
                                            input logic [15:0] filt);
    edge_hits = now_v & ~was_v & filt;
  endfunction

  wire osg_pkg::osg_op_t op = osg_pkg::osg_op_t'(cmd_op);

  wire is_rd_cond  = cmd_valid && (op == osg_pkg::OSG_OP_READ_COND);
  wire is_rd_event = cmd_valid && (op == osg_pkg::OSG_OP_READ_EVENT);
  wire is_rd_rise  = cmd_valid && (op == osg_pkg::OSG_OP_READ_RISE);
  wire is_rd_fall  = cmd_valid && (op == osg_pkg::OSG_OP_READ_FALL);
  wire is_rd_mask  = cmd_valid && (op == osg_pkg::OSG_OP_READ_MASK);
  wire is_wr_rise  = cmd_valid && (op == osg_pkg::OSG_OP_WRITE_RISE);
  wire is_wr_fall  = cmd_valid && (op == osg_pkg::OSG_OP_WRITE_FALL);
  wire is_wr_mask  = cmd_valid && (op == osg_pkg::OSG_OP_WRITE_MASK);
  wire is_cls      = cmd_valid && (op == osg_pkg::OSG_OP_CLEAR_STATUS);
  wire is_sup_on   = cmd_valid && (op == osg_pkg::OSG_OP_SUPPRESS_ON);
  wire is_sup_off  = cmd_valid && (op == osg_pkg::OSG_OP_SUPPRESS_OFF);
  wire is_read     = is_rd_cond | is_rd_event | is_rd_rise | is_rd_fall | is_rd_mask;

  // flag order inside the synchroniser
  assign flag_raw = {bit_error_tester_syncing,
                     sweep_calc_active,
                     baseband_busy_summary,
                     dc_coupled_fm_null_active,
                     trigger_wait_active | (traffic_channel_sync_mode_en &
                                            traffic_channel_sync_armed),
                     bit_error_tester_measuring,
                     sweep_active,
                     settling_active,
                     iq_cal_active,
                     1'b0};

  osg_flag_sync #(
    .W (osg_pkg::OSG_NFLAGS)
  ) u_sync (
    .clk      (clk),
    .resetn   (resetn),
    .flag_in  (flag_raw),
    .flag_out (flag_sync)
  );

  // place each synchronised flag on its condition bit
  always_comb begin
    cond_live = '0;
    cond_live[osg_pkg::OSG_BIT_IQ_CAL]      = flag_sync[1];
    cond_live[osg_pkg::OSG_BIT_SETTLING]    = flag_sync[2];
    cond_live[osg_pkg::OSG_BIT_SWEEPING]    = flag_sync[3];
    cond_live[osg_pkg::OSG_BIT_MEASURING]   = flag_sync[4] & HAS_BIT_ERROR_TESTER;
    cond_live[osg_pkg::OSG_BIT_WAIT_TRIG]   = flag_sync[5];
    cond_live[osg_pkg::OSG_BIT_DC_NULL]     = flag_sync[6];
    cond_live[osg_pkg::OSG_BIT_BASEBAND]    = flag_sync[7];
    cond_live[osg_pkg::OSG_BIT_SWEEP_CALC]  = flag_sync[8];
    cond_live[osg_pkg::OSG_BIT_TESTER_SYNC] = flag_sync[9];
  end

  // unused and top bits forced low; reduced build drops optional bits
  assign cond_keep = REDUCED_FEATURE ? (osg_pkg::OSG_COND_USED & ~osg_pkg::OSG_COND_REDUCED)
                                     : osg_pkg::OSG_COND_USED;
  // condition freezes while maintenance is suppressed
  assign cond_nxt  = suppress_active ? operation_condition_r
                                     : (cond_live & cond_keep);

  // edge capture through the filters
  assign rise_hit  = edge_hits(cond_nxt, operation_condition_r, operation_rise_filter_r);
  assign fall_hit  = edge_hits(operation_condition_r, cond_nxt, operation_fall_filter_r);
  assign event_set = rise_hit | fall_hit;

  // clear by read or clear-status, new events win over the clear
  assign event_nxt = ((is_rd_event | is_cls) ? osg_pkg::OSG_RST_ZERO
                                             : operation_event_latch_r)
                     | event_set;

  assign rise_nxt = is_wr_rise ? cmd_wdata : operation_rise_filter_r;
  assign fall_nxt = is_wr_fall ? cmd_wdata : operation_fall_filter_r;
  assign mask_nxt = is_wr_mask ? cmd_wdata : operation_event_mask_r;

  assign suppress_nxt = is_sup_on ? 1'b1 : (is_sup_off ? 1'b0 : suppress_active);

  assign summary_nxt = |(event_nxt & mask_nxt);

  // read data selection
  always_comb begin
    if (is_rd_cond) begin
      read_data = operation_condition_r;
    end else if (is_rd_event) begin
      read_data = operation_event_latch_r;
    end else if (is_rd_rise) begin
      read_data = operation_rise_filter_r;
    end else if (is_rd_fall) begin
      read_data = operation_fall_filter_r;
    end else if (is_rd_mask) begin
      read_data = operation_event_mask_r;
    end else begin
      read_data = osg_pkg::OSG_RST_ZERO;
    end
  end

  assign rsp_valid_nxt = is_read;
  assign rsp_data_nxt  = is_read ? read_data : rsp_data;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      operation_condition_r <= osg_pkg::OSG_RST_ZERO;
    end else begin
      operation_condition_r <= cond_nxt;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      operation_rise_filter_r <= osg_pkg::OSG_RST_RISE;
    end else begin
      operation_rise_filter_r <= rise_nxt;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      operation_fall_filter_r <= osg_pkg::OSG_RST_FALL;
    end else begin
      operation_fall_filter_r <= fall_nxt;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      operation_event_latch_r <= osg_pkg::OSG_RST_ZERO;
    end else begin
      operation_event_latch_r <= event_nxt;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      operation_event_mask_r <= osg_pkg::OSG_RST_ZERO;
    end else begin
      operation_event_mask_r <= mask_nxt;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      suppress_active <= 1'b0;
    end else begin
      suppress_active <= suppress_nxt;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      summary_out <= 1'b0;
    end else begin
      summary_out <= summary_nxt;
    end
  end

  // response pulse and held read word
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rsp_valid <= 1'b0;
      rsp_data  <= osg_pkg::OSG_RST_ZERO;
    end else begin
      rsp_valid <= rsp_valid_nxt;
      rsp_data  <= rsp_data_nxt;
    end
  end

endmodule

// ===== test/osg_status_group_checker.sv
// osg_status_group_checker: port assertions for the operation status group
// assumes one clk domain and an asynchronous active-low reset
`timescale 1ns/1ps
module osg_status_group_checker (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        cmd_valid,
  input wire logic [3:0]  cmd_op,
  input wire logic [15:0] cmd_wdata,
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic        summary_out,
  input wire logic        suppress_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [15:0] mask_r;
  wire rd_op = cmd_valid && (cmd_op <= 4'h4);
  // last written enable mask, to compare against queries
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) mask_r <= 16'h0000;
    else if (cmd_valid && cmd_op == 4'h7) mask_r <= cmd_wdata;
  sequence s_ev_rd;
    cmd_valid && cmd_op == 4'h1 && suppress_active;
  endsequence
  property p_rd_rsp;  rd_op |=> rsp_valid; endproperty
  property p_wr_none; !rd_op |=> !rsp_valid; endproperty
  property p_cond_zero;
    cmd_valid && cmd_op == 4'h0 |=> (rsp_data & ~16'h1e3b) == 16'h0000;
  endproperty
  property p_mask_rb; cmd_valid && cmd_op == 4'h4 |=> rsp_data == mask_r; endproperty
  property p_sup_on;  cmd_valid && cmd_op == 4'h9 |=> suppress_active; endproperty
  property p_sup_off; cmd_valid && cmd_op == 4'ha |=> !suppress_active; endproperty
  property p_mask0;   cmd_valid && cmd_op == 4'h7 && cmd_wdata == 16'h0 |=> !summary_out;
  endproperty
  property p_rdclr;   s_ev_rd ##1 !cmd_valid ##1 s_ev_rd |=> rsp_data == 16'h0000;
  endproperty
  property p_rst_sum; $rose(resetn) |-> !summary_out; endproperty
  a_rd_rsp: assert property (p_rd_rsp) else $error("no response to read");
  a_wr_none: assert property (p_wr_none) else $error("spurious response");
  a_cond_zero: assert property (p_cond_zero) else $error("unused bit set");
  a_mask_rb: assert property (p_mask_rb) else $error("mask readback wrong");
  a_sup_on: assert property (p_sup_on) else $error("suppress not set");
  a_sup_off: assert property (p_sup_off) else $error("suppress not cleared");
  a_mask0: assert property (p_mask0) else $error("summary with zero mask");
  a_rdclr: assert property (p_rdclr) else $error("event not cleared by read");
  a_rst_sum: assert property (p_rst_sum) else $error("summary high after reset");
endmodule
bind osg_status_group osg_status_group_checker u_chk (.clk(clk), .resetn(resetn),
  .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
  .rsp_data(rsp_data), .summary_out(summary_out), .suppress_active(suppress_active));

// ===== test/osg_sbr_model.sv
// osg_sbr_model: status byte register side, takes the summary into bit 7
// assumes the summary is a registered level in the clk domain
`timescale 1ns/1ps
module osg_sbr_model (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       summary_out,
  output logic      [7:0] status_byte
);
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) status_byte <= 8'h00;
    else status_byte <= {summary_out, 7'h00};
endmodule

// ===== test/tb_osg_status_group.sv
// tb_osg_status_group: command-sequence bench for the operation status group
// assumes default parameters on u_dut and the sbr model on its summary output
`timescale 1ns/1ps
module tb_osg_status_group;
  logic clk = 0, resetn = 0, cmd_valid = 0, rsp_valid, summary_out, suppress_active;
  logic [3:0] cmd_op = 4'h0;
  logic [15:0] cmd_wdata = 16'h0, rsp_data;
  logic [10:0] fl = 11'h000;
  logic [7:0] sb;
  logic [15:0] rsp_data_lite;
  logic summary_lite;
  int failures = 0, total_checks = 0, cyc = 0;
  always #2 clk = ~clk;
  osg_status_group u_dut (.clk(clk), .resetn(resetn), .iq_cal_active(fl[0]),
    .settling_active(fl[1]), .sweep_active(fl[2]), .bit_error_tester_measuring(fl[3]),
    .trigger_wait_active(fl[4]), .traffic_channel_sync_mode_en(fl[5]),
    .traffic_channel_sync_armed(fl[6]), .dc_coupled_fm_null_active(fl[7]),
    .baseband_busy_summary(fl[8]), .sweep_calc_active(fl[9]),
    .bit_error_tester_syncing(fl[10]), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .summary_out(summary_out), .suppress_active(suppress_active));
  // reduced build without the tester option, same stimulus
  osg_status_group #(.HAS_BIT_ERROR_TESTER(1'b0), .REDUCED_FEATURE(1'b1)) u_dut_lite (
    .clk(clk), .resetn(resetn), .iq_cal_active(fl[0]),
    .settling_active(fl[1]), .sweep_active(fl[2]), .bit_error_tester_measuring(fl[3]),
    .trigger_wait_active(fl[4]), .traffic_channel_sync_mode_en(fl[5]),
    .traffic_channel_sync_armed(fl[6]), .dc_coupled_fm_null_active(fl[7]),
    .baseband_busy_summary(fl[8]), .sweep_calc_active(fl[9]),
    .bit_error_tester_syncing(fl[10]), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_wdata(cmd_wdata), .rsp_valid(), .rsp_data(rsp_data_lite),
    .summary_out(summary_lite), .suppress_active());
  osg_sbr_model u_sbr (.clk(clk), .resetn(resetn), .summary_out(summary_out),
    .status_byte(sb));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("failures=%0d total_checks=%0d", failures, total_checks);
    if (failures == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one command per call; the response stands at the following falling edge
  task wr(input logic [3:0] op, input logic [15:0] d);
    @(negedge clk);
    cmd_valid = 1;
    cmd_op = op;
    cmd_wdata = d;
    @(negedge clk);
    cmd_valid = 0;
  endtask
  task rd(input logic [3:0] op, input logic [15:0] exp);
    wr(op, 16'h0);
    chk(rsp_data, exp);
  endtask
  task settle;
    repeat (8) @(negedge clk);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      test_done;
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    resetn = 1;
    rd(osg_pkg::OSG_OP_READ_MASK, 16'h0000);
    rd(osg_pkg::OSG_OP_READ_RISE, 16'hffff);
    rd(osg_pkg::OSG_OP_READ_FALL, 16'h0000);
    rd(osg_pkg::OSG_OP_READ_EVENT, 16'h0000);
    wr(osg_pkg::OSG_OP_WRITE_MASK, 16'h0208);
    rd(osg_pkg::OSG_OP_READ_MASK, 16'h0208);
    // trigger bit comes from the armed sync mode only
    fl = 11'h7ef;
    settle;
    rd(osg_pkg::OSG_OP_READ_COND, 16'h1e3b);
    chk(rsp_data_lite, 16'h0a2a);
    chk(summary_lite, 16'h0001);
    chk(summary_out, 1);
    chk(sb, 8'h80);
    rd(osg_pkg::OSG_OP_READ_EVENT, 16'h1e3b);
    rd(osg_pkg::OSG_OP_READ_EVENT, 16'h0000);
    chk(summary_out, 0);
    wr(osg_pkg::OSG_OP_WRITE_RISE, 16'h0000);
    wr(osg_pkg::OSG_OP_WRITE_FALL, 16'h0008);
    rd(osg_pkg::OSG_OP_READ_FALL, 16'h0008);
    fl[2] = 0;
    settle;
    rd(osg_pkg::OSG_OP_READ_COND, 16'h1e33);
    chk(summary_out, 1);
    wr(osg_pkg::OSG_OP_CLEAR_STATUS, 16'h0);
    chk(summary_out, 0);
    rd(osg_pkg::OSG_OP_READ_EVENT, 16'h0000);
    wr(osg_pkg::OSG_OP_WRITE_RISE, 16'hffff);
    wr(osg_pkg::OSG_OP_SUPPRESS_ON, 16'h0);
    chk(suppress_active, 1);
    fl[2] = 1;
    settle;
    rd(osg_pkg::OSG_OP_READ_COND, 16'h1e33);
    rd(osg_pkg::OSG_OP_READ_EVENT, 16'h0000);
    rd(osg_pkg::OSG_OP_READ_EVENT, 16'h0000);
    wr(osg_pkg::OSG_OP_SUPPRESS_OFF, 16'h0);
    chk(suppress_active, 0);
    repeat (2) @(negedge clk);
    rd(osg_pkg::OSG_OP_READ_EVENT, 16'h0008);
    wr(4'hb, 16'h1234);
    chk(rsp_valid, 0);
    rd(osg_pkg::OSG_OP_READ_MASK, 16'h0208);
    wr(osg_pkg::OSG_OP_WRITE_MASK, 16'h0000);
    chk(summary_out, 0);
    // armed sync alone must not hold the trigger bit without its mode
    fl[5] = 0;
    settle;
    rd(osg_pkg::OSG_OP_READ_COND, 16'h1e1b);
    fl[4] = 1;
    settle;
    rd(osg_pkg::OSG_OP_READ_COND, 16'h1e3b);
    test_done;
  end
endmodule
